// ---- hw/sapi_regs.svh ----
/*
  register indices, field positions, reset values and patterns of the sa6 pattern interrupt block.
  assumes: included by bare name wherever the macros are used; the guard keeps it single.
*/
`ifndef SAPI_REGS_SVH
`define SAPI_REGS_SVH
`define SAPI_STATUS_IDX 16'h0b0c
`define SAPI_ENABLE_IDX 16'h0b0d
`define SAPI_NIBBLE_IDX 16'h0b0e
`define SAPI_FLAGS_RST  8'h00
`define SAPI_BIT_ONES   7
`define SAPI_BIT_E      6
`define SAPI_BIT_C      5
`define SAPI_BIT_A      4
`define SAPI_BIT_EIGHT  3
`define SAPI_BIT_LOW    2
`define SAPI_BIT_MISC   1
`define SAPI_BIT_ZEROS  0
`define SAPI_PAT_ONES   4'hf
`define SAPI_PAT_E      4'he
`define SAPI_PAT_C      4'hc
`define SAPI_PAT_A      4'ha
`define SAPI_PAT_EIGHT  4'h8
`define SAPI_PAT_LOW3   3'h1
`define SAPI_PAT_ZEROS  4'h0
`endif

// ---- hw/sapi_pkg.sv ----
/*
  types and the pattern classifier shared by the sa6 pattern interrupt modules.
  assumes: sapi_regs.svh on the include path.
*/
package sapi_pkg;
  `include "sapi_regs.svh"
  typedef logic [7:0] sapi_flags_type;
  typedef enum logic [1:0] {
    SAPI_IDLE = 2'b01,
    SAPI_ACC  = 2'b10
  } sapi_apb_state_type;

  // one bit per monitored pattern, misc bit for every remaining value
  function automatic sapi_flags_type sapi_match(input logic [3:0] n);
    sapi_flags_type m;
    m = `SAPI_FLAGS_RST;
    m[`SAPI_BIT_ONES]  = (n == `SAPI_PAT_ONES);
    m[`SAPI_BIT_E]     = (n == `SAPI_PAT_E);
    m[`SAPI_BIT_C]     = (n == `SAPI_PAT_C);
    m[`SAPI_BIT_A]     = (n == `SAPI_PAT_A);
    m[`SAPI_BIT_EIGHT] = (n == `SAPI_PAT_EIGHT);
    m[`SAPI_BIT_LOW]   = (n[3:1] == `SAPI_PAT_LOW3);
    m[`SAPI_BIT_ZEROS] = (n == `SAPI_PAT_ZEROS);
    m[`SAPI_BIT_MISC]  = (m == `SAPI_FLAGS_RST);
    return m;
  endfunction
endpackage

// ---- hw/sapi_link_if.sv ----
/*
  internal carrier between detector, bus port and register core.
  assumes: all three ends on one clock.
*/
`timescale 1ns/100ps
interface sapi_link_if;
  logic [7:0] evt;
  logic [3:0] nib_q;
  logic       primed;
  logic       sel_status;
  logic       sel_enable;
  logic       sel_nibble;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] wdata;
  logic [7:0] rd_cap;
  logic [7:0] rd_word;
  modport detect (output evt, nib_q, primed);
  modport port (output sel_status, sel_enable, sel_nibble, wr_done, rd_done, wdata, rd_cap,
                input rd_word);
  modport core (input evt, nib_q, primed, sel_status, sel_enable, sel_nibble, wr_done, rd_done,
                wdata, rd_cap, output rd_word);
endinterface

// ---- hw/sapi_detect.sv ----
/*
  change detector for the debounced sa6 nibble.
  assumes: nibble comes from framer logic on clk, so no synchroniser.
*/
`timescale 1ns/100ps
`include "sapi_regs.svh"
module sapi_detect
  import sapi_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [3:0] sa6_nibble,
  sapi_link_if.detect    link
);
  logic [3:0]     nib_q;
  logic           primed;
  sapi_flags_type m_now;
  sapi_flags_type m_old;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nib_q  <= 4'h0;
      primed <= 1'b0;
    end else if (clk_en) begin
      nib_q  <= sa6_nibble;
      primed <= 1'b1;
    end
  end

  // no event on the first sample: the reset value of nib_q is not a real history
  always_comb begin
    m_now = sapi_match(sa6_nibble);
    m_old = sapi_match(nib_q);
    link.evt = m_now ^ m_old;
    link.evt[`SAPI_BIT_MISC] = m_now[`SAPI_BIT_MISC] && (sa6_nibble != nib_q);
    if (!primed) begin
      link.evt = `SAPI_FLAGS_RST;
    end
  end

  assign link.nib_q  = nib_q;
  assign link.primed = primed;
endmodule

// ---- hw/sapi_apb.sv ----
/*
  apb slave front end: one wait-free access phase, pslverr on unmapped words.
  assumes: apb master on clk, 32-bit data, word aligned addresses.
*/
`timescale 1ns/100ps
`include "sapi_regs.svh"
module sapi_apb
  import sapi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic     [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  sapi_link_if.port       link
);
  sapi_apb_state_type state;
  logic               hi_zero;
  logic               hit;
  logic               done;

  assign hi_zero         = (paddr[31:18] == 14'h0000);
  assign link.sel_status = hi_zero && (paddr[17:2] == `SAPI_STATUS_IDX);
  assign link.sel_enable = hi_zero && (paddr[17:2] == `SAPI_ENABLE_IDX);
  assign link.sel_nibble = hi_zero && (paddr[17:2] == `SAPI_NIBBLE_IDX);
  assign hit             = link.sel_status || link.sel_enable || link.sel_nibble;
  assign done            = clk_en && pready && psel && penable && !pslverr;
  assign link.wr_done    = done && pwrite;
  assign link.rd_done    = done && !pwrite;
  assign link.wdata      = pwdata[7:0];
  assign link.rd_cap     = prdata[7:0];

  // read data is sampled at setup, so the clear mask is exactly what software sees
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= SAPI_IDLE;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      case (state)
        SAPI_IDLE: begin
          if (psel && !penable) begin
            state   <= SAPI_ACC;
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= (hit && !pwrite) ? {24'h00_0000, link.rd_word} : 32'h0000_0000;
          end
        end
        SAPI_ACC: begin
          if (psel && penable) begin
            state   <= SAPI_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        default: begin
          state  <= SAPI_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- hw/sapi_irq.sv ----
/*
  sa6 pattern interrupt block: event status, enable mask, nibble readback, irq.
  assumes: debounced sa6 nibble and apb master both on clk; registers in low byte.
*/
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "sapi_regs.svh"
// How it works
// - reading status clears the bits read
// - status bits report events since last read
// - bit 0 sets entering or leaving 0000
// - bit 1 sets on other nibble values
// - enable bit 7 gates 1111 changes
// - enable bit 6 gates 1110 changes
// - enable bit 5 gates 1100 changes
// - enable bits read/write, zero suppresses interrupt
// - bits 7..2 latch six pattern changes
// - enable bits 4..0 gate remaining events
module sapi_irq
  import sapi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [3:0]  sa6_nibble,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic     [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  output logic            irq
);
  sapi_link_if link ();

  sapi_flags_type status;
  sapi_flags_type enable;
  sapi_flags_type clr;
  sapi_flags_type next_status;
  sapi_flags_type next_enable;

  sapi_detect u_detect (
    .clk        (clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .sa6_nibble (sa6_nibble),
    .link       (link)
  );

  sapi_apb u_apb (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .link    (link)
  );

  // clear only what was read or written as one; a new event in the same cycle wins
  always_comb begin
    clr = `SAPI_FLAGS_RST;
    if (link.rd_done && link.sel_status) begin
      clr = clr | link.rd_cap;
    end
    if (link.wr_done && link.sel_status) begin
      clr = clr | link.wdata;
    end
    next_status = (status & ~clr) | link.evt;
  end

  always_comb begin
    next_enable = enable;
    if (link.wr_done && link.sel_enable) begin
      next_enable = link.wdata;
    end
  end

  always_comb begin
    if (link.sel_status) begin
      link.rd_word = status;
    end else if (link.sel_enable) begin
      link.rd_word = enable;
    end else if (link.sel_nibble) begin
      link.rd_word = {4'h0, link.nib_q};
    end else begin
      link.rd_word = `SAPI_FLAGS_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= `SAPI_FLAGS_RST;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable <= `SAPI_FLAGS_RST;
    end else if (clk_en) begin
      enable <= next_enable;
    end
  end

  // built from next values so irq tracks status and enable in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_status & next_enable);
    end
  end

  sapi_flags_type m_in;
  sapi_flags_type m_hist;
  logic           en_wr;

  assign m_in   = sapi_match(sa6_nibble);
  assign m_hist = sapi_match(link.nib_q);
  assign en_wr  = link.wr_done && link.sel_enable;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_read_clear: assert property (
    clk_en && link.rd_done && link.sel_status
    |=> (status & $past(link.rd_cap) & ~$past(link.evt)) == 8'h00
  ) else $error("status bits read were not cleared");

  chk_reset_zero: assert property (
    $past(!rst_n)
    |-> status == 8'h00 && enable == 8'h00 && !irq
  ) else $error("status or enable not zero after reset");

  chk_event_sticky: assert property (
    clk_en && link.evt != 8'h00
    |=> (status & $past(link.evt)) == $past(link.evt)
  ) else $error("event did not set its status bit");

  chk_idle_holds: assert property (
    clk_en && link.evt == 8'h00 && !link.rd_done && !link.wr_done
    |=> status == $past(status)
  ) else $error("status changed without event or access");

  chk_zero_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'h0) != (link.nib_q == 4'h0))
    |=> status[0]
  ) else $error("0000 change did not set bit 0");

  chk_misc_flag: assert property (
    clk_en && link.primed && m_in[1] && sa6_nibble != link.nib_q
    |=> status[1]
  ) else $error("other combination did not set bit 1");

  chk_ones_irq: assert property (
    clk_en && link.evt[7] && enable[7] && !en_wr
    |=> irq && status[7]
  ) else $error("enabled 1111 change gave no interrupt");

  chk_e_irq: assert property (
    clk_en && link.evt[6] && enable[6] && !en_wr
    |=> irq && status[6]
  ) else $error("enabled 1110 change gave no interrupt");

  chk_c_irq: assert property (
    clk_en && link.evt[5] && enable[5] && !en_wr
    |=> irq && status[5]
  ) else $error("enabled 1100 change gave no interrupt");

  chk_enable_write: assert property (
    clk_en && en_wr
    |=> enable == $past(link.wdata)
  ) else $error("enable write not stored");

  chk_enable_read: assert property (
    clk_en && psel && !penable && !pwrite && link.sel_enable && !pready
    |=> prdata == {24'h00_0000, $past(enable)}
  ) else $error("enable readback wrong");

  chk_pattern_edges: assert property (
    clk_en && link.primed && ((m_in ^ m_hist) & 8'hfc) != 8'h00
    |=> (status & $past((m_in ^ m_hist) & 8'hfc)) == $past((m_in ^ m_hist) & 8'hfc)
  ) else $error("pattern change not latched in bits 7..2");

  chk_low_gate: assert property (
    clk_en && (link.evt[4:0] & enable[4:0]) != 5'h00 && !en_wr
    |=> irq
  ) else $error("enabled low event gave no interrupt");

  chk_irq_level: assert property (
    $past(rst_n) |-> irq == |(status & enable)
  ) else $error("irq disagrees with enabled status");

  chk_irq_masked: assert property (
    enable == 8'h00 |-> !irq
  ) else $error("irq with all enables off");

  chk_no_spurious_set: assert property (
    clk_en
    |=> (status & ~$past(status)) == ($past(link.evt) & ~$past(status))
  ) else $error("status bit rose without its event");

  chk_first_sample_quiet: assert property (
    !link.primed |-> link.evt == 8'h00
  ) else $error("event before the first nibble sample");

  chk_primed_after: assert property (
    clk_en |=> link.primed
  ) else $error("detector not armed after a sample");

  chk_freeze_all: assert property (
    !clk_en
    |=> status == $past(status) && enable == $past(enable) && irq == $past(irq) && pready == $past(pready)
  ) else $error("state moved while clock enable low");

  chk_freeze_detect: assert property (
    !clk_en |=> link.nib_q == $past(link.nib_q)
  ) else $error("nibble history moved while clock enable low");

  chk_unread_kept: assert property (
    clk_en && link.rd_done && link.sel_status
    |=> (status & ~$past(link.rd_cap)) == (($past(status) | $past(link.evt)) & ~$past(link.rd_cap))
  ) else $error("status read cleared bits it did not return");

  chk_write_clear: assert property (
    clk_en && link.wr_done && link.sel_status
    |=> (status & $past(link.wdata) & ~$past(link.evt)) == 8'h00
  ) else $error("write one did not clear status bits");

  chk_status_read: assert property (
    clk_en && psel && !penable && !pwrite && link.sel_status && !pready
    |=> prdata == {24'h00_0000, $past(status)}
  ) else $error("status readback wrong");

  chk_nibble_read: assert property (
    clk_en && psel && !penable && !pwrite && link.sel_nibble && !pready
    |=> prdata == {28'h000_0000, $past(link.nib_q)}
  ) else $error("nibble readback wrong");

  chk_nib_follows: assert property (
    clk_en |=> link.nib_q == $past(sa6_nibble)
  ) else $error("nibble history did not follow input");

  chk_same_quiet: assert property (
    sa6_nibble == link.nib_q |-> link.evt == 8'h00
  ) else $error("event without a nibble change");

  chk_low_ignores_x: assert property (
    sa6_nibble[3:1] == 3'h1 && link.nib_q[3:1] == 3'h1 |-> !link.evt[2]
  ) else $error("001x bit fired on its ignored bit");

  chk_zero_quiet: assert property (
    (sa6_nibble == 4'h0) == (link.nib_q == 4'h0) |-> !link.evt[0]
  ) else $error("0000 bit fired with no 0000 change");

  chk_misc_only_other: assert property (
    link.evt[1] |-> !(sa6_nibble inside {4'hf, 4'he, 4'hc, 4'ha, 4'h8, 4'h3, 4'h2, 4'h0})
  ) else $error("other flag fired on a listed pattern");

  chk_ones_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'hf) != (link.nib_q == 4'hf))
    |=> status[7]
  ) else $error("1111 change did not set bit 7");

  chk_e_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'he) != (link.nib_q == 4'he))
    |=> status[6]
  ) else $error("1110 change did not set bit 6");

  chk_c_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'hc) != (link.nib_q == 4'hc))
    |=> status[5]
  ) else $error("1100 change did not set bit 5");

  chk_a_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'ha) != (link.nib_q == 4'ha))
    |=> status[4]
  ) else $error("1010 change did not set bit 4");

  chk_eight_change: assert property (
    clk_en && link.primed && ((sa6_nibble == 4'h8) != (link.nib_q == 4'h8))
    |=> status[3]
  ) else $error("1000 change did not set bit 3");

  chk_low_change: assert property (
    clk_en && link.primed && ((sa6_nibble[3:1] == 3'h1) != (link.nib_q[3:1] == 3'h1))
    |=> status[2]
  ) else $error("001x change did not set bit 2");

  chk_enable_hold: assert property (
    clk_en && !en_wr |=> enable == $past(enable)
  ) else $error("enable changed without a write");

  chk_masked_quiet: assert property (
    clk_en && !en_wr && (status & enable) == 8'h00 && (link.evt & enable) == 8'h00
    |=> !irq
  ) else $error("irq from a masked event");

  chk_irq_drop: assert property (
    clk_en && link.rd_done && link.sel_status && (status & ~link.rd_cap & enable) == 8'h00
    && (link.evt & enable) == 8'h00
    |=> !irq
  ) else $error("irq stayed up after read");

  chk_err_no_write: assert property (
    clk_en && psel && penable && pready && pslverr |=> enable == $past(enable)
  ) else $error("unmapped write reached enable");

  chk_pready_pulse: assert property (
    clk_en && pready |=> !pready
  ) else $error("pready longer than one cycle");

  chk_err_data_zero: assert property (
    pready && pslverr |-> prdata == 32'h0000_0000
  ) else $error("unmapped access returned data");

  chk_upper_zero: assert property (
    prdata[31:8] == 24'h00_0000
  ) else $error("read data above bit 7 not zero");

  cov_read_clear: cover property (
    status != 8'h00 ##1 link.rd_done && link.sel_status ##1 status == 8'h00
  );

  cov_irq_rise: cover property (
    !irq ##1 irq
  );

  cov_misc_event: cover property (
    clk_en && link.evt[1]
  );

  cov_set_beats_clear: cover property (
    clk_en && link.rd_done && link.sel_status && (link.evt & link.rd_cap) != 8'h00
  );

  cov_unmapped: cover property (
    pready && pslverr
  );
endmodule

// ---- bench/sapi_far_end.sv ----
/*
  far-end model: remote e1 equipment presenting the debounced sa6 nibble.
  assumes: the bench requests a nibble by non-blocking assignment at a rising edge.
*/
`timescale 1ns/100ps
module sapi_far_end (
  input  wire logic       clk,
  input  wire logic [3:0] next_nibble,
  output logic      [3:0] sa6_nibble
);
  // value at time zero so the detector never samples an unknown
  initial sa6_nibble = 4'h0;
  // moves on a rising edge only, like framer logic on the same clock
  always @(posedge clk) begin
    sa6_nibble <= next_nibble;
  end
endmodule

// ---- bench/tb_e1_sa6_pattern_interrupts.sv ----
/*
  self-checking bench for the sa6 pattern interrupt block.
  assumes: sapi_pkg compiled first, far-end model and design on one clock.
*/
`timescale 1ns/100ps
`include "sapi_regs.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module tb_e1_sa6_pattern_interrupts;
  import sapi_pkg::*;
  typedef struct {
    logic [3:0]     nib;
    sapi_flags_type en;
    sapi_flags_type st;
  } sapi_row_type;
  localparam logic [31:0] status_addr = {14'h0000, `SAPI_STATUS_IDX, 2'b00};
  localparam logic [31:0] enable_addr = {14'h0000, `SAPI_ENABLE_IDX, 2'b00};
  localparam logic [31:0] bad_addr    = {14'h0000, 16'h0b0f, 2'b00};
  localparam logic [31:0] nibble_addr = {14'h0000, `SAPI_NIBBLE_IDX, 2'b00};
  logic        clk;
  logic        rst_n;
  logic        clk_en;
  logic [3:0]  next_nibble;
  logic [3:0]  sa6_nibble;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          check_count;
  // each step moves the nibble to a new value; rows 6 and 8 cross no pattern boundary
  sapi_row_type rows [10] = '{
    '{4'hf, 8'h80, 8'h81}, '{4'he, 8'h40, 8'hc0}, '{4'hc, 8'h20, 8'h60},
    '{4'ha, 8'h10, 8'h30}, '{4'h8, 8'h08, 8'h18}, '{4'h2, 8'h04, 8'h0c},
    '{4'h3, 8'hff, 8'h00}, '{4'h5, 8'h02, 8'h06}, '{4'h9, 8'hfd, 8'h02},
    '{4'h0, 8'h01, 8'h01}};

  sapi_far_end sapi_far_end_inst (.clk(clk), .next_nibble(next_nibble), .sa6_nibble(sa6_nibble));
  sapi_irq sapi_irq_inst (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sa6_nibble(sa6_nibble),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; no wait-state count assumed, only a bounded wait
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    next_nibble = 4'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, status_addr, 32'h0000_0000);
    `CHK("status reset", 32'h0000_0000, rd)
    apb(1'b0, enable_addr, 32'h0000_0000);
    `CHK("enable reset", 32'h0000_0000, rd)
    `CHK("irq reset", 1'b0, irq)
    foreach (rows[i]) begin
      apb(1'b1, enable_addr, {24'h00_0000, rows[i].en});
      @(posedge clk);
      next_nibble <= rows[i].nib;
      repeat (3) @(posedge clk);
      `CHK("irq", |(rows[i].st & rows[i].en), irq)
      apb(1'b0, status_addr, 32'h0000_0000);
      `CHK("status", {24'h00_0000, rows[i].st}, rd)
      repeat (2) @(posedge clk);
      `CHK("irq after read", 1'b0, irq)
      apb(1'b0, status_addr, 32'h0000_0000);
      `CHK("status after read", 32'h0000_0000, rd)
    end
    apb(1'b1, enable_addr, 32'h0000_00a5);
    apb(1'b0, enable_addr, 32'h0000_0000);
    `CHK("enable readback", 32'h0000_00a5, rd)
    apb(1'b0, bad_addr, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    // event pending when reset strikes mid-run
    apb(1'b1, enable_addr, 32'h0000_00ff);
    @(posedge clk);
    next_nibble <= 4'hf;
    repeat (3) @(posedge clk);
    `CHK("irq before reset", 1'b1, irq)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("irq in reset", 1'b0, irq)
    rst_n <= 1'b1;
    apb(1'b0, status_addr, 32'h0000_0000);
    `CHK("status after reset", 32'h0000_0000, rd)
    apb(1'b0, enable_addr, 32'h0000_0000);
    `CHK("enable after reset", 32'h0000_0000, rd)
    apb(1'b0, nibble_addr, 32'h0000_0000);
    `CHK("nibble readback", 32'h0000_000f, rd)
    // clock enable low holds the change back until it is raised
    apb(1'b1, enable_addr, 32'h0000_0001);
    @(posedge clk);
    clk_en <= 1'b0;
    next_nibble <= 4'h0;
    repeat (4) @(posedge clk);
    `CHK("irq while frozen", 1'b0, irq)
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("irq after thaw", 1'b1, irq)
    apb(1'b1, status_addr, 32'h0000_0080);
    // bit 0 fires again on the clearing edge of this read: set must win
    fork
      apb(1'b0, status_addr, 32'h0000_0000);
      begin
        @(posedge clk);
        next_nibble <= 4'h3;
      end
    join
    `CHK("status after write clear", 32'h0000_0001, rd)
    apb(1'b0, status_addr, 32'h0000_0000);
    `CHK("status set beats clear", 32'h0000_0005, rd)
    tally_and_finish();
  end
endmodule
